/* File: sbx_pkg.sv */
// constants and types for the subtract-with-borrow decode and execute block
package sbx_pkg;
  // opcodes of the subtract-with-borrow family
  localparam logic [7:0] SBX_OP_INDIRECT = 8'hd2;
  localparam logic [7:0] SBX_OP_PAGE_00 = 8'hd4;
  localparam logic [7:0] SBX_OP_PAGE_01 = 8'hd5;
  localparam logic [7:0] SBX_OP_PAGE_FE = 8'hd3;
  localparam logic [7:0] SBX_OP_LONG = 8'hd6;
  // high address byte implied by each short direct opcode
  localparam logic [7:0] SBX_HI_PAGE_00 = 8'h00;
  localparam logic [7:0] SBX_HI_PAGE_01 = 8'h01;
  localparam logic [7:0] SBX_HI_PAGE_FE = 8'hfe;
  // second-byte fields of the indirect opcode
  localparam int SBX_MODE_BIT = 7;
  localparam int SBX_IDX_MSB = 6;
  localparam int SBX_IDX_LSB = 1;
  localparam int SBX_WITH_C_BIT = 0;
  localparam int SBX_OFF_MSB = 6;
  // pointer word index of the base pointer
  localparam logic [5:0] SBX_BASE_INDEX = 6'h00;
  // program counter steps
  localparam logic [1:0] SBX_STEP_SHORT = 2'h2;
  localparam logic [1:0] SBX_STEP_LONG = 2'h3;
  localparam logic [1:0] SBX_STEP_NONE = 2'h0;
  // reset values
  localparam logic [7:0] SBX_ACC_RST = 8'h00;
  localparam logic [15:0] SBX_ADDR_RST = 16'h0000;
  // sequencer states
  typedef enum logic [0:0] {
    SBX_ST_IDLE = 1'b0,
    SBX_ST_EXEC = 1'b1
  } sbx_state_t;
endpackage

/* File: sbx_alu.sv */
// subtract accumulator minus borrow minus operand, with flag generation
`timescale 1ns/1ps
module sbx_alu (
  // operands
  input wire logic [7:0] acc_in,
  input wire logic [7:0] opnd_in,
  input wire logic borrow_in,
  // result and flags
  output logic [7:0] diff_out,
  output logic borrow_out,
  output logic half_borrow_out,
  output logic signed_wrap_out
);
  logic [8:0] full_diff;
  logic [4:0] low_diff;

  // nine-bit and five-bit differences expose the borrows out of bits 7 and 3
  assign full_diff = {1'b0, acc_in} - {1'b0, opnd_in} - {8'h00, borrow_in};
  assign low_diff = {1'b0, acc_in[3:0]} - {1'b0, opnd_in[3:0]} - {4'h0, borrow_in};
  assign diff_out = full_diff[7:0];
  assign borrow_out = full_diff[8];
  assign half_borrow_out = low_diff[4];
  // wrap when signs differ and the result sign leaves the minuend sign
  assign signed_wrap_out = (acc_in[7] ^ opnd_in[7]) & (acc_in[7] ^ full_diff[7]);
endmodule

/* File: sbx_exec.sv */
// decode and execute of the subtract-with-borrow instruction family
`timescale 1ns/1ps
module sbx_exec
  import sbx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // instruction issue from the fetch unit
  input wire logic issue,
  input wire logic [7:0] ins_op,
  input wire logic [7:0] ins_b1,
  input wire logic [7:0] ins_b2,
  output logic busy,
  // core state used by the operation
  input wire logic [7:0] acc_in,
  input wire logic borrow_flag_in,
  input wire logic [7:0] index_c,
  // pointer word read port, combinational data
  output logic ptr_rd,
  output logic [7:0] ptr_addr,
  input wire logic [15:0] ptr_data,
  // operand read port, combinational data
  output logic opnd_rd,
  output logic [15:0] opnd_addr,
  input wire logic [7:0] opnd_data,
  // results
  output logic done,
  output logic [7:0] acc_out,
  output logic borrow_flag,
  output logic half_borrow_flag,
  output logic signed_wrap_flag,
  output logic [1:0] pc_step,
  output logic bad_op
);
  // sequencer state, latched operand address and step
  sbx_state_t state_r;
  sbx_state_t state_nxt;
  logic [15:0] eff_addr_r;
  logic [15:0] eff_addr_nxt;
  logic [1:0] step_r;
  logic [1:0] step_nxt;

  // registered pulses and results
  logic done_r;
  logic bad_r;
  logic [7:0] acc_r;
  logic borrow_r;
  logic half_r;
  logic wrap_r;
  logic [1:0] pc_step_r;

  // sign-extend a byte to sixteen bits
  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction

  // sign-extend the seven-bit offset to sixteen bits
  function automatic logic [15:0] sext7(input logic [6:0] v);
    sext7 = {{9{v[6]}}, v};
  endfunction

  // opcode decode
  // issue is ignored while busy; the fetch unit must keep offering it
  wire idle = (state_r == SBX_ST_IDLE);
  wire go = idle & issue;
  wire is_ind = (ins_op == SBX_OP_INDIRECT);
  wire ind_base = is_ind & ins_b1[SBX_MODE_BIT];
  wire ind_ptr = is_ind & ~ins_b1[SBX_MODE_BIT] & ins_b1[SBX_WITH_C_BIT];
  wire is_p00 = (ins_op == SBX_OP_PAGE_00);
  wire is_p01 = (ins_op == SBX_OP_PAGE_01);
  wire is_pfe = (ins_op == SBX_OP_PAGE_FE);
  wire is_short = is_p00 | is_p01 | is_pfe;
  wire is_long = (ins_op == SBX_OP_LONG);
  wire legal = ind_base | ind_ptr | is_short | is_long;

  // implied high byte of the short direct forms
  wire [7:0] short_hi = is_p01 ? SBX_HI_PAGE_01 : (is_pfe ? SBX_HI_PAGE_FE : SBX_HI_PAGE_00);

  // pointer word selection: six-bit index, base pointer for offset form
  // the index field is six bits wide, so n above 63 cannot be encoded
  wire [5:0] ptr_index = ind_base ? SBX_BASE_INDEX : ins_b1[SBX_IDX_MSB:SBX_IDX_LSB];
  assign ptr_addr = {1'b0, ptr_index, 1'b0};
  assign ptr_rd = go & (ind_base | ind_ptr);

  // effective address of the indirect forms
  // all sums wrap modulo sixteen bits; no range check is made
  wire [15:0] addr_ptr_c = ptr_data + sext8(index_c);
  wire [15:0] addr_base_off = ptr_data + sext7(ins_b1[SBX_OFF_MSB:0]);
  wire [15:0] addr_long = {ins_b2, ins_b1};

  // operand read: issue cycle for short direct, second cycle otherwise
  // acc_in and the borrow flag are taken in the cycle of this read
  wire exec_now = go & is_short;
  wire exec_late = (state_r == SBX_ST_EXEC);
  assign opnd_rd = exec_now | exec_late;
  assign opnd_addr = exec_late ? eff_addr_r : {short_hi, ins_b1};
  assign busy = ~idle;

  // arithmetic on the operand read this cycle
  logic [7:0] alu_diff;
  logic alu_borrow;
  logic alu_half;
  logic alu_wrap;

  sbx_alu u_alu (
    .acc_in(acc_in),
    .opnd_in(opnd_data),
    .borrow_in(borrow_flag_in),
    .diff_out(alu_diff),
    .borrow_out(alu_borrow),
    .half_borrow_out(alu_half),
    .signed_wrap_out(alu_wrap)
  );

  // next state, latched address and program counter step
  // short direct forms never leave idle; the others spend one cycle in exec
  always_comb begin
    state_nxt = state_r;
    eff_addr_nxt = eff_addr_r;
    step_nxt = step_r;
    case (state_r)
      SBX_ST_IDLE: begin
        if (go & ind_ptr) begin
          state_nxt = SBX_ST_EXEC;
          eff_addr_nxt = addr_ptr_c;
          step_nxt = SBX_STEP_SHORT;
        end else if (go & ind_base) begin
          state_nxt = SBX_ST_EXEC;
          eff_addr_nxt = addr_base_off;
          step_nxt = SBX_STEP_SHORT;
        end else if (go & is_long) begin
          state_nxt = SBX_ST_EXEC;
          eff_addr_nxt = addr_long;
          step_nxt = SBX_STEP_LONG;
        end
      end
      SBX_ST_EXEC: begin
        state_nxt = SBX_ST_IDLE;
      end
      default: begin
        state_nxt = SBX_ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= SBX_ST_IDLE;
      eff_addr_r <= SBX_ADDR_RST;
      step_r <= SBX_STEP_NONE;
    end else begin
      state_r <= state_nxt;
      eff_addr_r <= eff_addr_nxt;
      step_r <= step_nxt;
    end
  end

  // one-cycle pulses: done after an execute edge, bad_op after an unknown opcode or an illegal indirect form
  wire exec_any = exec_now | exec_late;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      done_r <= 1'b0;
      bad_r <= 1'b0;
    end else begin
      done_r <= exec_any;
      bad_r <= go & ~legal;
    end
  end

  // accumulator result, loaded only at the execute edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_r <= SBX_ACC_RST;
    end else if (exec_any) begin
      acc_r <= alu_diff;
    end
  end

  // borrow, half borrow and wrap flags, loaded with the accumulator
  always_ff @(posedge clk) begin
    if (!nrst) begin
      borrow_r <= 1'b0;
      half_r <= 1'b0;
      wrap_r <= 1'b0;
    end else if (exec_any) begin
      borrow_r <= alu_borrow;
      half_r <= alu_half;
      wrap_r <= alu_wrap;
    end
  end

  // program counter step of the instruction just executed
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pc_step_r <= SBX_STEP_NONE;
    end else if (exec_any) begin
      pc_step_r <= exec_late ? step_r : SBX_STEP_SHORT;
    end
  end

  // one-cycle pulses
  assign done = done_r;
  assign bad_op = bad_r;

  // results, held until the next execute edge
  assign acc_out = acc_r;
  assign borrow_flag = borrow_r;
  assign half_borrow_flag = half_r;
  assign signed_wrap_flag = wrap_r;
  assign pc_step = pc_step_r;
endmodule

/* File: sbx_exec_asserts.sv */
// assertions on the ports of the subtract-with-borrow execute block
`timescale 1ns/1ps
module sbx_exec_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // issue and core state
  input wire logic issue,
  input wire logic [7:0] ins_op,
  input wire logic [7:0] ins_b1,
  input wire logic busy,
  input wire logic [7:0] acc_in,
  input wire logic borrow_flag_in,
  input wire logic [7:0] index_c,
  // memory ports
  input wire logic ptr_rd,
  input wire logic [7:0] ptr_addr,
  input wire logic [15:0] ptr_data,
  input wire logic opnd_rd,
  input wire logic [15:0] opnd_addr,
  input wire logic [7:0] opnd_data,
  // results
  input wire logic done,
  input wire logic [7:0] acc_out,
  input wire logic borrow_flag,
  input wire logic half_borrow_flag,
  input wire logic signed_wrap_flag,
  input wire logic [1:0] pc_step
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // decoded forms and reference values
  wire tk = issue && !busy;
  wire ix = tk && ins_op == 8'hd2 && !ins_b1[7] && ins_b1[0];
  wire of = tk && ins_op == 8'hd2 && ins_b1[7];
  wire sh = tk && (ins_op == 8'hd4 || ins_op == 8'hd5 || ins_op == 8'hd3);
  wire [15:0] ea_ix = ptr_data + {{8{index_c[7]}}, index_c};
  wire [15:0] ea_of = ptr_data + {{9{ins_b1[6]}}, ins_b1[6:0]};
  wire [8:0] dif = {1'b0, acc_in} - {1'b0, opnd_data} - 9'(borrow_flag_in);
  wire [4:0] hd = {1'b0, acc_in[3:0]} - {1'b0, opnd_data[3:0]} - 5'(borrow_flag_in);
  wire hb = hd[4];
  wire ovf = (acc_in[7] != opnd_data[7]) && (dif[7] != acc_in[7]);
  // second cycle busy, then done
  sequence two_step;
    busy ##1 done;
  endsequence
  a_short_done: assert property (sh |=> done && !busy && pc_step == 2'h2)
    else $error("short form timing wrong");
  a_long_steps: assert property (tk && ins_op == 8'hd6 |=> two_step ##0 pc_step == 2'h3)
    else $error("long form timing wrong");
  a_index_steps: assert property (ix |=> two_step ##0 pc_step == 2'h2)
    else $error("index form timing wrong");
  a_ptr_fetch_addr: assert property (ix |-> ptr_addr == {1'b0, ins_b1[6:1], 1'b0})
    else $error("pointer address wrong");
  a_base_ptr_zero: assert property (of |-> ptr_addr == 8'h00)
    else $error("base pointer address wrong");
  a_ptr_read_strobe: assert property (ptr_rd == (ix || of))
    else $error("pointer read strobe wrong");
  a_index_sum: assert property (ix |=> opnd_rd && opnd_addr == $past(ea_ix))
    else $error("index sum wrong");
  a_offset_sum: assert property (of |=> opnd_rd && opnd_addr == $past(ea_of))
    else $error("offset sum wrong");
  a_result_acc: assert property (opnd_rd |=> {borrow_flag, acc_out} == $past(dif))
    else $error("difference wrong");
  a_flag_bits: assert property (opnd_rd |=> half_borrow_flag == $past(hb) && signed_wrap_flag == $past(ovf))
    else $error("flags wrong");
endmodule

bind sbx_exec sbx_exec_asserts u_sbx_exec_asserts (.clk, .nrst, .issue, .ins_op, .ins_b1, .busy, .acc_in,
  .borrow_flag_in, .index_c, .ptr_rd, .ptr_addr, .ptr_data, .opnd_rd, .opnd_addr, .opnd_data, .done, .acc_out,
  .borrow_flag, .half_borrow_flag, .signed_wrap_flag, .pc_step);

/* File: tb_top.sv */
// self-checking bench for the subtract-with-borrow execute block
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, nrst = 0, issue = 0, cin = 0, busy, ptr_rd, opnd_rd, done, cy, hc, ov, bad_op;
  logic [7:0] op = 0, b1 = 0, b2 = 0, acc = 0, idx = 0, od = 0, pa = 0, ptr_addr, acc_out;
  logic [15:0] pw = 0, ea = 0, opnd_addr;
  logic [1:0] pc_step;
  int n_errors = 0, comparisons = 0;
  // rows: op b1 b2 pointer index acc operand address pointer-address borrow-in
  logic [95:0] rows [10] = '{96'hd4_34_00_0000_00_00_55_0034_00_01, 96'hd5_10_00_0000_00_55_55_0110_00_00,
    96'hd3_20_00_0000_00_ab_55_fe20_00_01, 96'hd6_00_02_0000_00_80_01_0200_00_00,
    96'hd6_34_00_0000_00_7f_ff_0034_00_00, 96'hd2_03_00_0055_04_55_55_0059_02_00,
    96'hd2_7f_00_1000_80_00_01_0f80_7e_01, 96'hd2_84_00_0055_33_55_55_0059_00_01,
    96'hd2_c0_00_0100_00_10_20_00c0_00_00, 96'hd2_bf_00_0100_00_ff_0f_013f_00_01};
  // memories answer only at the expected address
  wire [15:0] ptr_data = (ptr_addr === pa) ? pw : ~pw;
  wire [7:0] opnd_data = (opnd_addr === ea) ? od : ~od;
  sbx_exec u_sbx_exec (.clk, .nrst, .issue, .ins_op(op), .ins_b1(b1), .ins_b2(b2), .busy, .acc_in(acc),
    .borrow_flag_in(cin), .index_c(idx), .ptr_rd, .ptr_addr, .ptr_data, .opnd_rd, .opnd_addr, .opnd_data,
    .done, .acc_out, .borrow_flag(cy), .half_borrow_flag(hc), .signed_wrap_flag(ov), .pc_step, .bad_op);
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // reference difference and flags: result, borrow, half borrow, wrap
  function automatic logic [10:0] ref_sub(input logic [7:0] a, input logic [7:0] b, input logic c);
    logic [8:0] d;
    logic [4:0] h;
    d = {1'b0, a} - {1'b0, b} - 9'(c);
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(c);
    return {d[7:0], d[8], h[4], (a[7] != b[7]) && (d[7] != a[7])};
  endfunction
  // issue one row and check results and cycle count
  task automatic run(input logic [95:0] r);
    int n;
    n = 0;
    @(negedge clk);
    {op, b1, b2, pw, idx, acc, od, ea, pa} = r[95:8];
    cin = r[0];
    issue = 1;
    @(negedge clk);
    issue = 0;
    while (done !== 1'b1 && n < 4) begin
      n++;
      @(negedge clk);
    end
    if (n == 4) begin
      chk({15'h0, done}, 16'h1);
      tally_and_finish();
    end else begin
      chk(16'(n), (op == 8'hd4 || op == 8'hd5 || op == 8'hd3) ? 16'h0 : 16'h1);
      chk(16'({acc_out, cy, hc, ov}), 16'(ref_sub(acc, od, cin)));
      chk(16'(pc_step), (op == 8'hd6) ? 16'h3 : 16'h2);
    end
  endtask
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1;
    foreach (rows[i]) run(rows[i]);
    // plain pointer form without index register is refused
    op = 8'hd2;
    b1 = 8'h02;
    issue = 1;
    @(negedge clk);
    issue = 0;
    chk(16'({bad_op, done}), 16'h2);
    chk(16'({acc_out, cy, hc, ov}), 16'(ref_sub(acc, od, cin)));
    @(negedge clk);
    // a second issue while busy is ignored
    {op, b1, b2, acc, od, ea, cin} = {8'hd6, 8'h00, 8'h02, 8'h10, 8'h01, 16'h0200, 1'b0};
    issue = 1;
    @(negedge clk);
    {op, b1} = {8'hd4, 8'h34};
    @(negedge clk);
    issue = 0;
    chk(16'({done, pc_step}), 16'h7);
    chk(16'({acc_out, cy, hc, ov}), 16'(ref_sub(acc, od, cin)));
    @(negedge clk);
    chk(16'(done), 16'h0);
    // reset in the middle of a long form
    op = 8'hd6;
    issue = 1;
    @(negedge clk);
    issue = 0;
    nrst = 0;
    @(negedge clk);
    nrst = 1;
    chk(16'({busy, done, acc_out, pc_step}), 16'h0);
    // first issue after the release
    run(rows[0]);
    tally_and_finish();
  end
endmodule
